// ---- cfbch_core.v ----
`timescale 1ns/100ps
`default_nettype none
`include "cfbch_map.vh"
module cfbch_core #(
  parameter NCTR = 4,
  parameter EXEC_TICKS = 4'h2,
  parameter TASK_CYCLES = `CFBCH_TASK_CYCLES
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Handshake outputs
  output reg done_flag,
  output reg busy_flag,
  output reg cmd_cancelled_flag,
  output reg error_flag,
  output reg at_speed_flag,
  output reg at_rate_flag,
  output reg [7:0] fault_code_out,
  // Dedicated counter outputs
  output reg [NCTR*32-1:0] counter_preset_out,
  output reg [NCTR*2-1:0] counter_time_base_out
);
  // Run executes; hold keeps the result; pulse shows it one tick
  localparam S_IDLE = 2'h0;
  localparam S_RUN = 2'h1;
  localparam S_HOLD = 2'h2;
  localparam S_PULSE = 2'h3;

  wire tick;
  reg [1:0] state;
  reg start;
  reg start_q;
  reg [31:0] cmd_word;
  reg [31:0] value_word;
  reg [31:0] cfg_word;
  reg [15:0] task_len;
  reg [31:0] lat_cmd;
  reg [31:0] lat_value;
  reg [31:0] result_value;
  reg [3:0] exec_cnt;
  reg abort_req;
  // Parameter store per counter, written only by set commands; cap_reg copies p_preset every cycle
  reg [31:0] p_preset [0:NCTR-1];
  reg [31:0] p_wrap [0:NCTR-1];
  reg [1:0] p_tb [0:NCTR-1];
  reg [31:0] p_lim0 [0:NCTR-1];
  reg [31:0] p_lim1 [0:NCTR-1];
  reg [31:0] cap_reg [0:NCTR-1];
  reg [7:0] eval_code;
  reg [31:0] eval_result;
  reg [31:0] next_prdata;
  reg [7:0] last_fault;

  wire wr = psel && penable && pwrite;
  wire rd_setup = psel && !penable;
  wire [7:0] l_ref = lat_cmd[`CFBCH_CMD_REF_LSB +: 8];
  wire [7:0] l_sel = lat_cmd[`CFBCH_CMD_SEL_LSB +: 8];
  wire [1:0] l_op = lat_cmd[`CFBCH_CMD_OP_LSB +: 2];
  wire [7:0] l_cap = lat_cmd[`CFBCH_CMD_CAPIDX_LSB +: 8];
  wire ref_ok = (l_ref < NCTR) && cfg_word[`CFBCH_CFG_PRESENT_LSB + l_ref[2:0]];
  wire [1:0] ri = l_ref[1:0];
  // Start is looked at once per task tick, as a scanned input
  wire start_rise = start && !start_q;
  wire start_fall = !start && start_q;
  wire finish = (state == S_RUN) && tick && (exec_cnt == 4'h0);

  cfbch_tick #(
    .W(16)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .period(task_len),
    .tick(tick)
  );

  // Command evaluation against the latched inputs
  // Priority: link, reference, capture, selector, then value
  always @* begin
    eval_code = `CFBCH_FAULT_NONE;
    eval_result = 32'h00000000;
    if (cfg_word[`CFBCH_CFG_LINKERR]) begin
      eval_code = `CFBCH_FAULT_LINK_FAILURE;
    end else if (!ref_ok) begin
      eval_code = `CFBCH_FAULT_BAD_REFERENCE;
    end else if (l_op == `CFBCH_OP_CAPTURE) begin
      if (!cfg_word[`CFBCH_CFG_CAPTURE_LSB + l_ref[2:0]] || l_cap != 8'h00) begin
        eval_code = `CFBCH_FAULT_CAPTURE_ABSENT;
      end else begin
        eval_result = cap_reg[ri];
      end
    end else if (l_op == `CFBCH_OP_DIAG) begin
      // Last fault survives the clear on the next start
      eval_result = {24'h000000, last_fault};
    end else begin
      case (l_sel)
        `CFBCH_SEL_PRESET: begin
          eval_result = p_preset[ri];
          if (l_op == `CFBCH_OP_SET &&
              (lat_value < p_lim0[ri] || lat_value < p_lim1[ri])) begin
            eval_code = `CFBCH_FAULT_BAD_VALUE;
          end
        end
        `CFBCH_SEL_WRAP_VALUE: begin
          eval_result = p_wrap[ri];
        end
        `CFBCH_SEL_TIME_BASE: begin
          eval_result = {30'h00000000, p_tb[ri]};
          if (l_op == `CFBCH_OP_SET && lat_value > `CFBCH_TB_ONE_MINUTE) begin
            eval_code = `CFBCH_FAULT_BAD_VALUE;
          end
        end
        `CFBCH_SEL_LIMIT_ZERO: begin
          eval_result = p_lim0[ri];
          if (l_op == `CFBCH_OP_SET && lat_value > p_preset[ri]) begin
            eval_code = `CFBCH_FAULT_BAD_VALUE;
          end
        end
        `CFBCH_SEL_LIMIT_ONE: begin
          eval_result = p_lim1[ri];
          if (l_op == `CFBCH_OP_SET && lat_value > p_preset[ri]) begin
            eval_code = `CFBCH_FAULT_BAD_VALUE;
          end
        end
        default: begin
          eval_code = `CFBCH_FAULT_BAD_SELECTOR;
        end
      endcase
    end
  end

  // APB register writes; dedicated outputs have no address of their own
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start <= 1'b0;
      abort_req <= 1'b0;
      cmd_word <= `CFBCH_INIT_CMD;
      value_word <= `CFBCH_INIT_VALUE;
      cfg_word <= 32'h00000000;
      task_len <= TASK_CYCLES;
    end else begin
      // Abort only lives while a run can take it; a write the same cycle wins
      if (state != S_RUN) begin
        abort_req <= 1'b0;
      end
      if (wr) begin
        case (paddr)
          `CFBCH_OFS_CTRL: begin
            start <= pwdata[`CFBCH_CTRL_START];
            if (pwdata[`CFBCH_CTRL_ABORT]) begin
              abort_req <= 1'b1;
            end
          end
          `CFBCH_OFS_CMD: cmd_word <= pwdata;
          `CFBCH_OFS_VALUE: value_word <= pwdata;
          `CFBCH_OFS_CFG: cfg_word <= pwdata;
          // A zero period counts as one; the tick would fire every cycle either way
          `CFBCH_OFS_TASK: task_len <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // APB answer: zero wait states, unmapped address errors
  always @* begin
    case (paddr)
      `CFBCH_OFS_CTRL: next_prdata = {31'h00000000, start};
      `CFBCH_OFS_CMD: next_prdata = cmd_word;
      `CFBCH_OFS_VALUE: next_prdata = value_word;
      `CFBCH_OFS_STATUS: next_prdata = {16'h0000, fault_code_out, 2'h0, at_rate_flag,
        at_speed_flag, error_flag, cmd_cancelled_flag, busy_flag, done_flag};
      `CFBCH_OFS_RESULT: next_prdata = done_flag ? result_value : 32'h00000000;
      `CFBCH_OFS_CFG: next_prdata = cfg_word;
      `CFBCH_OFS_TASK: next_prdata = {16'h0000, task_len};
      default: next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      // Error answers with ready in the same access cycle
      pslverr <= rd_setup && (paddr > `CFBCH_OFS_TASK || paddr[1:0] != 2'h0);
      if (rd_setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Handshake state machine, stepped by task cycle ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      start_q <= 1'b0;
      lat_cmd <= 32'h00000000;
      lat_value <= 32'h00000000;
      exec_cnt <= 4'h0;
      done_flag <= 1'b0;
      busy_flag <= 1'b0;
      cmd_cancelled_flag <= 1'b0;
      error_flag <= 1'b0;
      at_speed_flag <= 1'b0;
      at_rate_flag <= 1'b0;
      fault_code_out <= `CFBCH_FAULT_NONE;
      result_value <= 32'h00000000;
      last_fault <= `CFBCH_FAULT_NONE;
    end else if (tick) begin
      start_q <= start;
      if (start_rise) begin
        // New start supersedes any running command silently
        lat_cmd <= cmd_word;
        lat_value <= value_word;
        exec_cnt <= EXEC_TICKS;
        state <= S_RUN;
        busy_flag <= 1'b1;
        done_flag <= 1'b0;
        cmd_cancelled_flag <= 1'b0;
        error_flag <= 1'b0;
        fault_code_out <= `CFBCH_FAULT_NONE;
      end else begin
        case (state)
          S_RUN: begin
            // Abort beats a finish that falls on the same tick
            if (abort_req) begin
              busy_flag <= 1'b0;
              cmd_cancelled_flag <= 1'b1;
              state <= start ? S_HOLD : S_PULSE;
            end else if (exec_cnt != 4'h0) begin
              exec_cnt <= exec_cnt - 4'h1;
            end else begin
              busy_flag <= 1'b0;
              state <= start ? S_HOLD : S_PULSE;
              if (eval_code != `CFBCH_FAULT_NONE) begin
                error_flag <= 1'b1;
                fault_code_out <= eval_code;
                last_fault <= eval_code;
              end else begin
                done_flag <= 1'b1;
                result_value <= eval_result;
              end
            end
          end
          S_HOLD: begin
            // Results stand until start falls
            if (start_fall) begin
              done_flag <= 1'b0;
              cmd_cancelled_flag <= 1'b0;
              error_flag <= 1'b0;
              fault_code_out <= `CFBCH_FAULT_NONE;
              state <= S_IDLE;
            end
          end
          S_PULSE: begin
            // Start fell during the run: result shown for one tick
            done_flag <= 1'b0;
            cmd_cancelled_flag <= 1'b0;
            error_flag <= 1'b0;
            fault_code_out <= `CFBCH_FAULT_NONE;
            state <= S_IDLE;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Counter parameters, written only by completed set commands
  genvar gi;
  generate
    for (gi = 0; gi < NCTR; gi = gi + 1) begin : g_ctr
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          p_preset[gi] <= 32'h00000000;
          p_wrap[gi] <= 32'h00000000;
          p_tb[gi] <= 2'h0;
          p_lim0[gi] <= 32'h00000000;
          p_lim1[gi] <= 32'h00000000;
          cap_reg[gi] <= 32'h00000000;
          counter_preset_out[gi*32 +: 32] <= 32'h00000000;
          counter_time_base_out[gi*2 +: 2] <= 2'h0;
        end else begin
          // Same gating as the done branch: refused or superseded sets write nothing
          if (tick && finish && !abort_req && !start_rise && eval_code == `CFBCH_FAULT_NONE
              && l_op == `CFBCH_OP_SET && ri == gi) begin
            case (l_sel)
              `CFBCH_SEL_PRESET: p_preset[gi] <= lat_value;
              `CFBCH_SEL_WRAP_VALUE: p_wrap[gi] <= lat_value;
              `CFBCH_SEL_TIME_BASE: p_tb[gi] <= lat_value[1:0];
              `CFBCH_SEL_LIMIT_ZERO: p_lim0[gi] <= lat_value;
              `CFBCH_SEL_LIMIT_ONE: p_lim1[gi] <= lat_value;
              default: begin
              end
            endcase
          end
          // Capture register is modelled as a snapshot of the preset
          cap_reg[gi] <= p_preset[gi];
          // Dedicated outputs follow the store one cycle later
          counter_preset_out[gi*32 +: 32] <= p_preset[gi];
          counter_time_base_out[gi*2 +: 2] <= p_tb[gi];
        end
      end
    end
  endgenerate
endmodule // cfbch_core
`default_nettype wire

// ---- cfbch_map.vh ----
`ifndef CFBCH_MAP_VH
`define CFBCH_MAP_VH
// APB register offsets (byte addresses)
`define CFBCH_OFS_CTRL 12'h000
`define CFBCH_OFS_CMD 12'h004
`define CFBCH_OFS_VALUE 12'h008
`define CFBCH_OFS_STATUS 12'h00C
`define CFBCH_OFS_RESULT 12'h010
`define CFBCH_OFS_CFG 12'h014
`define CFBCH_OFS_TASK 12'h018
// Control fields
`define CFBCH_CTRL_START 0
`define CFBCH_CTRL_ABORT 1
// Command word fields
`define CFBCH_CMD_REF_LSB 0
`define CFBCH_CMD_SEL_LSB 8
`define CFBCH_CMD_OP_LSB 16
`define CFBCH_CMD_CAPIDX_LSB 24
// Operations
`define CFBCH_OP_GET 2'h0
`define CFBCH_OP_SET 2'h1
`define CFBCH_OP_CAPTURE 2'h2
`define CFBCH_OP_DIAG 2'h3
// Status fields
`define CFBCH_ST_DONE 0
`define CFBCH_ST_BUSY 1
`define CFBCH_ST_CANCEL 2
`define CFBCH_ST_ERROR 3
`define CFBCH_ST_SPEED 4
`define CFBCH_ST_RATE 5
`define CFBCH_ST_CODE_LSB 8
// Config fields
`define CFBCH_CFG_PRESENT_LSB 0
`define CFBCH_CFG_CAPTURE_LSB 8
`define CFBCH_CFG_LINKERR 16
// Fault codes
`define CFBCH_FAULT_NONE 8'h00
`define CFBCH_FAULT_BAD_REFERENCE 8'h01
`define CFBCH_FAULT_BAD_SELECTOR 8'h02
`define CFBCH_FAULT_BAD_VALUE 8'h03
`define CFBCH_FAULT_LINK_FAILURE 8'h04
`define CFBCH_FAULT_CAPTURE_ABSENT 8'h05
// Parameter selectors
`define CFBCH_SEL_PRESET 8'h00
`define CFBCH_SEL_WRAP_VALUE 8'h01
`define CFBCH_SEL_TIME_BASE 8'h02
`define CFBCH_SEL_LIMIT_ZERO 8'h04
`define CFBCH_SEL_LIMIT_ONE 8'h05
// Time bases
`define CFBCH_TB_TENTH_SECOND 32'h00000000
`define CFBCH_TB_ONE_SECOND 32'h00000001
`define CFBCH_TB_TEN_SECONDS 32'h00000002
`define CFBCH_TB_ONE_MINUTE 32'h00000003
// Initial command inputs
`define CFBCH_INIT_CMD 32'h00000000
`define CFBCH_INIT_VALUE 32'h00000000
// Task cycle length in pclk cycles
`define CFBCH_TASK_CYCLES 16'h0004
`endif

// ---- cfbch_tick.v ----
`timescale 1ns/100ps
`default_nettype none
module cfbch_tick #(
  parameter W = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Period in pclk cycles, at least one
  input wire [W-1:0] period,
  // One-cycle task step pulse
  output reg tick
);
  reg [W-1:0] count;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {W{1'b0}};
      tick <= 1'b0;
    end else if (count + {{(W-1){1'b0}}, 1'b1} >= period) begin
      count <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // cfbch_tick
`default_nettype wire

// ---- cfbch_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module cfbch_properties #(
  parameter NCTR = 4
) (
  // Clock, reset and APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Handshake
  input wire done_flag,
  input wire busy_flag,
  input wire cmd_cancelled_flag,
  input wire error_flag,
  input wire at_speed_flag,
  input wire at_rate_flag,
  input wire [7:0] fault_code_out,
  // Counter copies
  input wire [NCTR*32-1:0] counter_preset_out,
  input wire [NCTR*2-1:0] counter_time_base_out
);
  wire ended;
  assign ended = done_flag || cmd_cancelled_flag || error_flag;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad_setup;
    s_setup ##0 (paddr > 12'h018);
  endsequence
  a_flags_exclusive: assert property (
    $onehot0({done_flag, busy_flag, cmd_cancelled_flag, error_flag, at_speed_flag,
    at_rate_flag})) else $error("result flags overlap");
  a_busy_handover: assert property (
    $fell(busy_flag) |-> ended) else $error("busy fell without result");
  a_result_from_busy: assert property (
    $rose(ended) |-> $past(busy_flag)) else $error("result without run");
  a_error_code: assert property (
    error_flag |-> fault_code_out inside {[8'h01:8'h05]}) else $error("bad fault code");
  a_code_clear: assert property (
    !error_flag |-> fault_code_out == 8'h00) else $error("stale fault code");
  a_no_motion: assert property (
    !at_speed_flag && !at_rate_flag) else $error("motion flag set");
  a_zero_wait: assert property (
    s_setup |=> pready) else $error("pready late");
  a_bad_addr: assert property (
    s_bad_setup |=> pslverr && pready) else $error("unmapped not refused");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("pslverr without pready");
  a_out_by_cmd: assert property (
    $changed(counter_preset_out) || $changed(counter_time_base_out)
    |-> $past(busy_flag) || $past(busy_flag, 2)) else $error("output moved alone");
endmodule // cfbch_properties
bind cfbch_core cfbch_properties #(.NCTR(NCTR)) u_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .done_flag, .busy_flag, .cmd_cancelled_flag, .error_flag,
  .at_speed_flag, .at_rate_flag, .fault_code_out, .counter_preset_out,
  .counter_time_base_out);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cfbch_map.vh"
`define CK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] rv;
  logic [31:0] res;
  logic [31:0] seen;
  logic se;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, done_flag, busy_flag, cmd_cancelled_flag, error_flag;
  wire at_speed_flag, at_rate_flag;
  wire [7:0] fault_code_out;
  wire [127:0] counter_preset_out;
  wire [7:0] counter_time_base_out;
  always #2.5 pclk = ~pclk;
  cfbch_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .done_flag, .busy_flag, .cmd_cancelled_flag, .error_flag,
    .at_speed_flag, .at_rate_flag, .fault_code_out, .counter_preset_out,
    .counter_time_base_out);
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    $display("BAD wait exp done got timeout");
    summarize();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) hang();
    rv = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  // Poll status until masked bits are zero (z) or nonzero
  task automatic poll(input logic [31:0] m, input logic z);
    int i;
    i = 0;
    do begin
      rd(`CFBCH_OFS_STATUS);
      seen = seen | rv;
      i++;
    end while ((~|(rv & m) !== z) && i < 100);
    if (~|(rv & m) !== z) hang();
  endtask
  task automatic go(input logic [31:0] c, input logic [31:0] v);
    wr(`CFBCH_OFS_CMD, c);
    wr(`CFBCH_OFS_VALUE, v);
    wr(`CFBCH_OFS_CTRL, 32'h1);
    seen = 32'h0;
  endtask
  task automatic fin;
    wr(`CFBCH_OFS_CTRL, 32'h0);
    poll(32'hFFFF, 1'h1);
    `CK("cleared", 32'h0, rv)
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] v, input logic [7:0] f);
    go(c, v);
    poll(32'hD, 1'h0);
    `CK("status", {16'h0, f, 4'h0, f != 8'h0, 2'h0, f == 8'h0}, rv)
    rd(`CFBCH_OFS_RESULT);
    res = rv;
    fin();
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rd(`CFBCH_OFS_STATUS);
    `CK("reset status", 32'h0, rv)
    rd(`CFBCH_OFS_CMD);
    `CK("initial cmd", `CFBCH_INIT_CMD, rv)
    rd(12'h01C);
    `CK("unmapped", 1'h1, se)
    wr(`CFBCH_OFS_TASK, 32'h14);
    wr(`CFBCH_OFS_CFG, 32'h10F);
    rd(`CFBCH_OFS_TASK);
    `CK("task len", 32'h14, rv)
    run(32'h10000, 32'h64, 8'h0);
    `CK("preset out", 32'h64, counter_preset_out[31:0])
    run(32'h0, 32'h0, 8'h0);
    `CK("get preset", 32'h64, res)
    run(32'h10400, 32'h32, 8'h0);
    run(32'h10500, 32'hC8, 8'h3);
    run(32'h10000, 32'h14, 8'h3);
    run(32'h10100, 32'h7, 8'h0);
    for (int t = 0; t < 4; t++) begin
      run(32'h10200, t, 8'h0);
      `CK("time base", t[1:0], counter_time_base_out[1:0])
    end
    run(32'h10200, 32'h4, 8'h3);
    run(32'h300, 32'h0, 8'h2);
    run(32'h600, 32'h0, 8'h2);
    run(32'h4, 32'h0, 8'h1);
    `CK("no result", 32'h0, res)
    run(32'h20001, 32'h0, 8'h5);
    run(32'h1020000, 32'h0, 8'h5);
    run(32'h20000, 32'h0, 8'h0);
    `CK("capture", 32'h64, res)
    wr(`CFBCH_OFS_CFG, 32'h1010F);
    run(32'h0, 32'h0, 8'h4);
    wr(`CFBCH_OFS_CFG, 32'h10F);
    run(32'h30000, 32'h0, 8'h0);
    `CK("diag code", 32'h4, res)
    // Inputs rewritten mid-run, start left high
    go(32'h0, 32'h0);
    poll(32'h2, 1'h0);
    wr(`CFBCH_OFS_CMD, 32'h600);
    poll(32'hD, 1'h0);
    `CK("latched cmd", 32'h1, rv)
    wr(`CFBCH_OFS_CTRL, 32'h1);
    repeat (10) rd(`CFBCH_OFS_STATUS);
    `CK("level start", 32'h1, rv)
    rd(`CFBCH_OFS_CMD);
    `CK("held cmd", 32'h600, rv)
    fin();
    go(32'h0, 32'h0);
    poll(32'h2, 1'h0);
    wr(`CFBCH_OFS_CTRL, 32'h3);
    poll(32'hD, 1'h0);
    `CK("cancelled", 32'h4, rv)
    fin();
    // Start dropped before the end
    go(32'h0, 32'h0);
    poll(32'h2, 1'h0);
    wr(`CFBCH_OFS_CTRL, 32'h0);
    poll(32'hD, 1'h0);
    `CK("late result", 32'h1, rv)
    poll(32'hFFFF, 1'h1);
    // Restart while a failing command runs
    go(32'h600, 32'h0);
    poll(32'h2, 1'h0);
    wr(`CFBCH_OFS_CMD, 32'h0);
    wr(`CFBCH_OFS_CTRL, 32'h0);
    repeat (22) @(posedge pclk);
    wr(`CFBCH_OFS_CTRL, 32'h1);
    poll(32'hD, 1'h0);
    `CK("superseded", 32'h1, rv)
    `CK("no old error", 1'h0, seen[3])
    fin();
    summarize();
  end
endmodule // tb
`default_nettype wire
